// ### shared/cit_pkg.sv
`default_nettype none

package cit_pkg;

    // ------------------------------------------------------------
    // clock and throughput
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned MAX_CLK_HZ   = 25_000_000;
    localparam int unsigned PEAK_MIPS    = 25;
    localparam int unsigned TOTAL_INSTR  = 109;
    localparam int unsigned ONE_CYC_CNT  = 26;
    localparam int unsigned TWO_CYC_CNT  = 50;
    localparam int unsigned THREE_CYC_CNT = 14;

    // ------------------------------------------------------------
    // status word layout and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PSTAT_SFR_ADDR = 8'hD0;
    localparam int unsigned CARRY_BIT      = 7;
    localparam int unsigned PARITY_BIT     = 0;
    localparam logic [7:0]  PSTAT_RST      = 8'h00;
    localparam logic [7:0]  ACC_RST        = 8'h00;
    localparam logic [15:0] PC_RST         = 16'h0000;
    localparam logic [15:0] DP_RST         = 16'h0000;

    // ------------------------------------------------------------
    // opcodes handled inside the sequencer
    // ------------------------------------------------------------
    localparam logic [7:0] OP_CLR_A       = 8'hE4;
    localparam logic [7:0] OP_CPL_A       = 8'hF4;
    localparam logic [7:0] OP_ROTL        = 8'h23;
    localparam logic [7:0] OP_ROTL_CARRY  = 8'h33;
    localparam logic [7:0] OP_ROTR        = 8'h03;
    localparam logic [7:0] OP_ROTR_CARRY  = 8'h13;
    localparam logic [7:0] OP_SWAP_A      = 8'hC4;
    localparam logic [7:0] OP_CLR_CARRY   = 8'hC3;
    localparam logic [7:0] OP_SET_CARRY   = 8'hD3;
    localparam logic [7:0] OP_CPL_CARRY   = 8'hB3;
    localparam logic [7:0] OP_JMP_CARRY   = 8'h40;
    localparam logic [7:0] OP_JMP_NCARRY  = 8'h50;
    localparam logic [7:0] OP_LOAD_DP     = 8'h90;
    localparam logic [7:0] OP_CODE_RD_DP  = 8'h93;
    localparam logic [7:0] OP_CODE_RD_PC  = 8'h83;
    localparam logic [7:0] OP_MOV_A_IMM   = 8'h74;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CL_NOP,
        CL_ACC,
        CL_CARRY,
        CL_BRANCH,
        CL_DP_LOAD,
        CL_CODE_RD,
        CL_IMM_A,
        CL_DATA
    } cit_class_t;

    typedef struct packed {
        logic [1:0] len;
        logic [2:0] cyc;
        cit_class_t cls;
    } cit_dec_t;

    typedef struct packed {
        cit_class_t cls;
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] acc;
    } cit_issue_t;

    typedef struct packed {
        logic       acc_we;
        logic [7:0] acc;
        logic       pstat_we;
        logic [7:0] pstat;
    } cit_wb_t;

endpackage

`default_nettype wire

// ### design/cit_decode.sv
`default_nettype none

module cit_decode (
    // opcode in
    input  wire logic [7:0]       opcode,
    // length, cycles, class out
    output cit_pkg::cit_dec_t     info
);

    // ------------------------------------------------------------
    // table of bytes and clocks per opcode
    // ------------------------------------------------------------
    always_comb begin
        info = '{len: 2'd1, cyc: 3'd1, cls: cit_pkg::CL_NOP};
        casez (opcode)
            8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: begin
                info = '{2'd1, 3'd1, cit_pkg::CL_ACC};
            end
            8'hC3, 8'hD3, 8'hB3: begin
                info = '{2'd1, 3'd1, cit_pkg::CL_CARRY};
            end
            8'h40, 8'h50: begin
                info = '{2'd2, 3'd2, cit_pkg::CL_BRANCH};
            end
            8'h90: begin
                info = '{2'd3, 3'd3, cit_pkg::CL_DP_LOAD};
            end
            8'h93, 8'h83: begin
                info = '{2'd1, 3'd3, cit_pkg::CL_CODE_RD};
            end
            8'h74: begin
                info = '{2'd2, 3'd2, cit_pkg::CL_IMM_A};
            end
            8'b1110_1???, 8'b1111_1???, 8'b1100_1???: begin
                info = '{2'd1, 3'd1, cit_pkg::CL_DATA};
            end
            8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: begin
                info = '{2'd1, 3'd2, cit_pkg::CL_DATA};
            end
            8'b1010_1???, 8'b0111_1???, 8'b1000_1???,
            8'b1000_011?, 8'b1010_011?, 8'b0111_011?: begin
                info = '{2'd2, 3'd2, cit_pkg::CL_DATA};
            end
            8'hE5, 8'hF5, 8'hC5, 8'hC0, 8'hD0, 8'hC2, 8'hD2, 8'hB2: begin
                info = '{2'd2, 3'd2, cit_pkg::CL_DATA};
            end
            8'h85, 8'h75, 8'h63: begin
                info = '{2'd3, 3'd3, cit_pkg::CL_DATA};
            end
            8'b1110_001?, 8'b1111_001?, 8'hE0, 8'hF0: begin
                info = '{2'd1, 3'd3, cit_pkg::CL_DATA};
            end
            default: begin
                info = '{2'd1, 3'd1, cit_pkg::CL_NOP};
            end
        endcase
    end

endmodule

`default_nettype wire

// ### design/cit_core.sv
// Function
// - durations count plain system clocks, no machine-cycle grouping.
// - a conditional branch not taken finishes one clock sooner than taken.
// - opcodes, addressing and status flag effects match the classic family.
// - system clock at most 25 MHz, single-cycle ops give 25 MIPS peak.
// - 109 instructions; 26 take one clock, 50 two, 14 three.
// - xor immediate into direct byte: three bytes, three clocks.
// - clear, complement, rotates, rotates via carry, swap: one clock.
// - load accumulator from bank register 1/1, direct or immediate 2/2.
// - accumulator to or from indirect internal RAM: one byte, two clocks.
// - bank register from accumulator 1/1, from direct or immediate 2/2.
// - direct from acc, register, indirect 2/2; direct or immediate 3/3.
// - indirect RAM from direct byte or immediate: two bytes, two clocks.
// - load 16-bit data pointer with immediate: three bytes, three clocks.
// - code byte read into acc, base pointer or counter: 1 byte, 3 clocks.
// - external data moves either way, 8 or 16-bit address: 1 byte, 3.
// - push or pop of a direct byte: two bytes, two clocks.
// - exchange register 1/1, direct 2/2, indirect or low nibble 1/2.
// - carry clear, set, complement 1/1; same on direct bit 2/2.
// - carry sits in status word bit 7, status word at address 0xD0.
`default_nettype none

module cit_core (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    // program memory
    output logic [15:0]               code_addr,
    input  wire logic [7:0]           code_rdata,
    // datapath hand-off
    output logic                      issue_vld,
    output cit_pkg::cit_issue_t       issue,
    input  wire cit_pkg::cit_wb_t     wb,
    // architectural state
    output logic [7:0]                acc,
    output logic [7:0]                prog_status,
    output logic [15:0]               data_pointer,
    output logic [15:0]               prog_counter,
    // sequencing status
    output logic                      retire,
    output logic [2:0]                retire_cycles,
    output logic                      illegal_op,
    output logic [15:0]               retired_count
);

    // ------------------------------------------------------------
    // clock rate check
    // ------------------------------------------------------------
    localparam bit CLK_IN_RANGE =
        cit_pkg::CLK_HZ <= cit_pkg::MAX_CLK_HZ;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic {
        ST_DECODE,
        ST_EXTEND
    } cit_state_t;

    cit_state_t          state_q;
    cit_state_t          state_d;
    logic [2:0]          cnt_q;
    logic [2:0]          cnt_d;
    logic [7:0]          op_q;
    logic [7:0]          b1_q;
    logic [7:0]          b2_q;
    logic [15:0]         pc_q;
    logic [15:0]         pc_d;
    logic [15:0]         addr_q;
    logic [15:0]         addr_d;
    logic [7:0]          acc_q;
    logic [7:0]          acc_d;
    logic [7:0]          pstat_q;
    logic [7:0]          pstat_d;
    logic [15:0]         dp_q;
    logic [15:0]         dp_d;
    cit_pkg::cit_issue_t issue_q;
    logic                issue_vld_q;
    logic                retire_q;
    logic [2:0]          rcyc_q;
    logic                ill_q;
    logic [15:0]         rcount_q;

    // ------------------------------------------------------------
    // decode of the current opcode
    // ------------------------------------------------------------
    wire                 first;
    wire [7:0]           cur_op;
    cit_pkg::cit_dec_t   dec;

    assign first  = state_q == ST_DECODE;
    assign cur_op = first ? code_rdata : op_q;

    cit_decode u_decode (
        .opcode (cur_op),
        .info   (dec)
    );

    // ------------------------------------------------------------
    // branch condition and cycle budget
    // ------------------------------------------------------------
    wire                 carry;
    wire                 is_branch;
    wire                 cond;
    wire                 taken;
    wire [2:0]           cyc_eff;
    wire                 last;

    assign carry     = pstat_q[cit_pkg::CARRY_BIT];
    assign is_branch = dec.cls == cit_pkg::CL_BRANCH;
    assign cond      = (cur_op == cit_pkg::OP_JMP_CARRY) ? carry : ~carry;
    assign taken     = is_branch && cond;
    // taken branch gets one extra clock for the target fetch
    assign cyc_eff   = dec.cyc + {2'b00, taken};
    assign last      = cnt_q == (cyc_eff - 3'd1);

    // ------------------------------------------------------------
    // operand bytes, live on the bus in their own cycle
    // ------------------------------------------------------------
    wire [7:0]           opnd1;
    wire [7:0]           opnd2;

    assign opnd1 = (cnt_q == 3'd1) ? code_rdata : b1_q;
    assign opnd2 = (cnt_q == 3'd2) ? code_rdata : b2_q;

    // ------------------------------------------------------------
    // next program counter and fetch address
    // ------------------------------------------------------------
    wire [15:0]          len16;
    wire [15:0]          rel16;
    wire [15:0]          fall_pc;
    wire [15:0]          next_pc;
    wire                 fetch_more;
    wire [15:0]          code_base;
    wire [15:0]          code_rd_addr;
    wire                 is_code_rd;

    assign len16        = {14'h0000, dec.len};
    assign rel16        = {{8{b1_q[7]}}, b1_q};
    assign fall_pc      = pc_q + len16;
    assign next_pc      = taken ? fall_pc + rel16 : fall_pc;
    assign fetch_more   = (cnt_q + 3'd1) < {1'b0, dec.len};
    assign is_code_rd   = dec.cls == cit_pkg::CL_CODE_RD;
    assign code_base    = (cur_op == cit_pkg::OP_CODE_RD_DP) ?
                          dp_q : pc_q + 16'h0001;
    assign code_rd_addr = code_base + {8'h00, acc_q};

    always_comb begin
        addr_d = addr_q;
        if (last) begin
            addr_d = next_pc;
        end else if (first && is_code_rd) begin
            addr_d = code_rd_addr;
        end else if (fetch_more) begin
            addr_d = pc_q + {13'h0000, cnt_q} + 16'h0001;
        end
    end

    assign pc_d = last ? next_pc : pc_q;

    // ------------------------------------------------------------
    // cycle counter and state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_DECODE: begin
                if (last) begin
                    cnt_d = 3'd0;
                end else begin
                    state_d = ST_EXTEND;
                    cnt_d   = 3'd1;
                end
            end
            ST_EXTEND: begin
                if (last) begin
                    state_d = ST_DECODE;
                    cnt_d   = 3'd0;
                end else begin
                    cnt_d = cnt_q + 3'd1;
                end
            end
            default: begin
                state_d = ST_DECODE;
                cnt_d   = 3'd0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // local execution: accumulator, carry, pointer
    // ------------------------------------------------------------
    logic [7:0]          acc_base;
    logic [7:0]          pstat_base;
    logic [7:0]          acc_x;
    logic                carry_x;

    // datapath write-back lands first, local ops act on top of it
    assign acc_base   = wb.acc_we ? wb.acc : acc_q;
    assign pstat_base = wb.pstat_we ? wb.pstat : pstat_q;

    always_comb begin
        acc_x   = acc_base;
        carry_x = pstat_base[cit_pkg::CARRY_BIT];
        dp_d    = dp_q;
        if (last) begin
            case (dec.cls)
                cit_pkg::CL_ACC: begin
                    case (cur_op)
                        cit_pkg::OP_CLR_A: begin
                            acc_x = 8'h00;
                        end
                        cit_pkg::OP_CPL_A: begin
                            acc_x = ~acc_base;
                        end
                        cit_pkg::OP_ROTL: begin
                            acc_x = {acc_base[6:0], acc_base[7]};
                        end
                        cit_pkg::OP_ROTR: begin
                            acc_x = {acc_base[0], acc_base[7:1]};
                        end
                        cit_pkg::OP_ROTL_CARRY: begin
                            acc_x   = {acc_base[6:0], carry_x};
                            carry_x = acc_base[7];
                        end
                        cit_pkg::OP_ROTR_CARRY: begin
                            acc_x   = {carry_x, acc_base[7:1]};
                            carry_x = acc_base[0];
                        end
                        cit_pkg::OP_SWAP_A: begin
                            acc_x = {acc_base[3:0], acc_base[7:4]};
                        end
                        default: begin
                            acc_x = acc_base;
                        end
                    endcase
                end
                cit_pkg::CL_CARRY: begin
                    case (cur_op)
                        cit_pkg::OP_CLR_CARRY: begin
                            carry_x = 1'b0;
                        end
                        cit_pkg::OP_SET_CARRY: begin
                            carry_x = 1'b1;
                        end
                        cit_pkg::OP_CPL_CARRY: begin
                            carry_x = ~carry_x;
                        end
                        default: begin
                            carry_x = carry_x;
                        end
                    endcase
                end
                cit_pkg::CL_IMM_A: begin
                    acc_x = opnd1;
                end
                cit_pkg::CL_CODE_RD: begin
                    acc_x = b1_q;
                end
                cit_pkg::CL_DP_LOAD: begin
                    dp_d = {opnd1, opnd2};
                end
                default: begin
                    acc_x = acc_base;
                end
            endcase
        end
    end

    // parity tracks the accumulator as in the classic status word
    always_comb begin
        acc_d   = acc_x;
        pstat_d = pstat_base;
        pstat_d[cit_pkg::CARRY_BIT]  = carry_x;
        pstat_d[cit_pkg::PARITY_BIT] = ^acc_x;
    end

    // ------------------------------------------------------------
    // datapath issue
    // ------------------------------------------------------------
    wire                 issue_now;
    cit_pkg::cit_issue_t issue_d;

    assign issue_now = last && (dec.cls == cit_pkg::CL_DATA);
    assign issue_d   = '{cls: dec.cls, op: cur_op, b1: opnd1,
                         b2: opnd2, acc: acc_q};

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_DECODE;
            cnt_q   <= 3'd0;
            pc_q    <= cit_pkg::PC_RST;
            addr_q  <= cit_pkg::PC_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pc_q    <= pc_d;
            addr_q  <= addr_d;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            op_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
        end else begin
            if (first) begin
                op_q <= code_rdata;
            end
            if (cnt_q == 3'd1) begin
                b1_q <= code_rdata;
            end
            if (cnt_q == 3'd2) begin
                b2_q <= code_rdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q   <= cit_pkg::ACC_RST;
            pstat_q <= cit_pkg::PSTAT_RST;
            dp_q    <= cit_pkg::DP_RST;
        end else begin
            acc_q   <= acc_d;
            pstat_q <= pstat_d;
            dp_q    <= dp_d;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            issue_vld_q <= 1'b0;
            issue_q     <= '0;
        end else begin
            issue_vld_q <= issue_now;
            if (issue_now) begin
                issue_q <= issue_d;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            retire_q <= 1'b0;
            rcyc_q   <= 3'd0;
            ill_q    <= 1'b0;
            rcount_q <= 16'h0000;
        end else begin
            retire_q <= last;
            ill_q    <= last && (dec.cls == cit_pkg::CL_NOP);
            if (last) begin
                rcyc_q   <= cyc_eff;
                rcount_q <= rcount_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign code_addr     = addr_q;
    assign issue_vld     = issue_vld_q;
    assign issue         = issue_q;
    assign acc           = acc_q;
    assign prog_status   = pstat_q;
    assign data_pointer  = dp_q;
    assign prog_counter  = pc_q;
    assign retire        = retire_q;
    assign retire_cycles = rcyc_q;
    assign illegal_op    = ill_q;
    assign retired_count = rcount_q;

endmodule

`default_nettype wire

// ### tb/cit_mem_model.sv
`default_nettype none

module cit_mem_model (
    // clock
    input  wire logic                mclk,
    // program memory
    input  wire logic [15:0]         code_addr,
    output logic [7:0]               code_rdata,
    // datapath
    input  wire logic                issue_vld,
    input  wire cit_pkg::cit_issue_t issue,
    output cit_pkg::cit_wb_t         wb
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem [0:255];
    logic       ld_q = 1'b0;
    logic [7:0] op_q = 8'h00;
    wire logic  ld_acc = issue_vld && issue.op inside {8'hE6, 8'hE0, 8'hE8};

    initial foreach (mem[i]) mem[i] = 8'h00;

    // same-cycle read, datapath answers one cycle after the issue
    assign code_rdata = mem[code_addr[7:0]];
    assign wb = {ld_q, op_q ^ 8'h5A, 1'b0, 8'h00};

    always @(posedge mclk) begin
        ld_q <= ld_acc;
        op_q <= issue.op;
    end
endmodule

`default_nettype wire

// ### tb/cit_core_properties.sv
`default_nettype none

module cit_core_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // observed
    input wire logic [7:0]  code_rdata,
    input wire logic [7:0]  prog_status,
    input wire logic        issue_vld,
    input wire logic        retire,
    input wire logic [2:0]  retire_cycles,
    input wire logic        illegal_op,
    input wire logic [15:0] retired_count
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic       first_q;
    logic       seen_q;
    logic [3:0] gap_q;
    // cycle 0 of an instruction: opcode sits on code_rdata
    wire logic  start = retire || first_q;
    wire logic  op_acc = start && code_rdata inside {cit_pkg::OP_CLR_A,
        cit_pkg::OP_CPL_A, cit_pkg::OP_ROTL, cit_pkg::OP_ROTL_CARRY,
        cit_pkg::OP_ROTR, cit_pkg::OP_ROTR_CARRY, cit_pkg::OP_SWAP_A};

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 1'b1;
            seen_q  <= 1'b0;
            gap_q   <= 4'h0;
        end else begin
            first_q <= 1'b0;
            seen_q  <= seen_q | retire;
            gap_q   <= retire ? 4'h1 : gap_q + 4'h1;
        end
    end

    gap_match_a: assert property (retire && seen_q |->
        gap_q == {1'b0, retire_cycles}) else $error("gap differs");
    cycles_range_a: assert property (retire |->
        retire_cycles inside {3'h1, 3'h2, 3'h3}) else $error("bad count");
    acc_single_a: assert property (op_acc |=>
        retire && retire_cycles == 3'h1) else $error("acc op length");
    carry_clear_a: assert property (start &&
        code_rdata == cit_pkg::OP_CLR_CARRY |=> retire && !prog_status[7])
        else $error("carry not cleared");
    carry_set_a: assert property (start &&
        code_rdata == cit_pkg::OP_SET_CARRY |=> retire && prog_status[7])
        else $error("carry not set");
    branch_skip_a: assert property (start &&
        code_rdata == cit_pkg::OP_JMP_CARRY && !prog_status[7] |=>
        !retire ##1 retire && retire_cycles == 3'h2)
        else $error("untaken branch length");
    branch_taken_a: assert property (start &&
        code_rdata == cit_pkg::OP_JMP_NCARRY && !prog_status[7] |=>
        !retire [*2] ##1 retire && retire_cycles == 3'h3)
        else $error("taken branch length");
    dp_load_a: assert property (start &&
        code_rdata == cit_pkg::OP_LOAD_DP |=>
        !retire [*2] ##1 retire && retire_cycles == 3'h3)
        else $error("pointer load length");
    issue_end_a: assert property (issue_vld |-> retire)
        else $error("issue without retire");
    illegal_one_a: assert property (illegal_op |->
        retire && retire_cycles == 3'h1) else $error("illegal op length");
    count_step_a: assert property ($changed(retired_count) |->
        retire && retired_count == $past(retired_count) + 16'h0001)
        else $error("retire count step");

    cover property (op_acc);
    cover property (start && code_rdata == cit_pkg::OP_JMP_CARRY);
    cover property (issue_vld);
endmodule

bind cit_core cit_core_properties chk_u (.mclk(mclk), .sys_rst(sys_rst),
    .code_rdata(code_rdata), .prog_status(prog_status),
    .issue_vld(issue_vld), .retire(retire), .retire_cycles(retire_cycles),
    .illegal_op(illegal_op), .retired_count(retired_count));

`default_nettype wire

// ### tb/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                mclk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [15:0]         code_addr;
    logic [7:0]          code_rdata;
    logic                issue_vld;
    cit_pkg::cit_issue_t issue;
    cit_pkg::cit_wb_t    wb;
    logic [7:0]          acc;
    logic [7:0]          prog_status;
    logic [15:0]         data_pointer;
    logic [15:0]         prog_counter;
    logic                retire;
    logic [2:0]          retire_cycles;
    int                  err_count = 0;
    int                  check_count = 0;
    int                  cyc = 0;
    int                  gap = 0;
    logic [2:0]          gap_q[$];
    logic [2:0]          rep_q[$];

    cit_core dut_u (.mclk(mclk), .sys_rst(sys_rst), .code_addr(code_addr),
        .code_rdata(code_rdata), .issue_vld(issue_vld), .issue(issue),
        .wb(wb), .acc(acc), .prog_status(prog_status),
        .data_pointer(data_pointer), .prog_counter(prog_counter),
        .retire(retire),
        .retire_cycles(retire_cycles), .illegal_op(), .retired_count());
    cit_mem_model mem_u (.mclk(mclk), .code_addr(code_addr),
        .code_rdata(code_rdata), .issue_vld(issue_vld), .issue(issue),
        .wb(wb));

    always #25 mclk = ~mclk;

    // measured clocks between retirements, with a hang limit
    always @(posedge mclk) begin
        gap = sys_rst ? 0 : gap + 1;
        if (!sys_rst && retire) begin
            gap_q.push_back(gap[2:0]);
            rep_q.push_back(retire_cycles);
            gap = 0;
        end
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // reset, load program, wait for n retirements
    task automatic run(input logic [7:0] prog[$], input int n);
        int k;
        @(posedge mclk);
        #2 sys_rst = 1'b1;
        for (k = 0; k < 256; k++) begin
            mem_u.mem[k] = (k < prog.size()) ? prog[k] : 8'h00;
        end
        gap_q.delete();
        rep_q.delete();
        repeat (12) @(posedge mclk);
        #2 sys_rst = 1'b0;
        k = 0;
        while (gap_q.size() < n && k < 200) begin
            @(posedge mclk);
            #2 k++;
        end
    endtask

    // first retirement after reset is not timed
    task automatic expect_cyc(input logic [2:0] exp[$]);
        foreach (exp[i]) begin
            check(gap_q[i+1], exp[i]);
            check(rep_q[i+1], exp[i]);
        end
    endtask

    task automatic s_acc();
        run({8'h00, 8'hE4, 8'h74, 8'h81, 8'h23, 8'hF4, 8'h03, 8'hC4,
            8'h13, 8'h33}, 9);
        expect_cyc({3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1});
        check(acc, 16'h00E7);
        check(prog_status, 16'h0000);
    endtask

    task automatic s_carry();
        run({8'h00, 8'hD3, 8'h40, 8'h00, 8'hB3, 8'h40, 8'h00, 8'h50,
            8'h00, 8'hC3, 8'h50, 8'h00, 8'hD3}, 9);
        expect_cyc({3'h1, 3'h3, 3'h1, 3'h2, 3'h3, 3'h1, 3'h3, 3'h1});
        check(prog_status, 16'h0080);
    endtask

    task automatic s_data();
        run({8'h00, 8'h63, 8'h30, 8'h5A, 8'hE6, 8'hF2, 8'h85, 8'h30,
            8'h31, 8'hC5, 8'h30, 8'hD6, 8'hE0, 8'hC0, 8'h30, 8'h88,
            8'h30, 8'h78, 8'h05, 8'hE8}, 12);
        expect_cyc({3'h3, 3'h2, 3'h3, 3'h3, 3'h2, 3'h2, 3'h3, 3'h2,
            3'h2, 3'h2, 3'h1});
        check(issue.op, 16'h00E8);
        repeat (2) @(posedge mclk);
        #2;
        check(acc, 16'h00B2);
        check(prog_status, 16'h0000);
    endtask

    task automatic s_dp();
        run({8'h00, 8'h90, 8'h00, 8'h04, 8'h74, 8'h02, 8'h93, 8'hE4,
            8'h83, 8'hA5}, 7);
        expect_cyc({3'h3, 3'h2, 3'h3, 3'h1, 3'h3, 3'h1});
        check(data_pointer, 16'h0004);
        check(prog_counter, 16'h000B);
        check(acc, 16'h00A5);
    endtask

    initial begin
        s_acc();
        s_carry();
        s_data();
        s_dp();
        tally_and_finish();
    end
endmodule

`default_nettype wire
